// >>> hdl/acd_pkg.sv
// Package for the arbitration command decoder: command fields, encodings, states.
// Assumes one dword command word presented at a time by the command fetch logic.
package acd_pkg;
   localparam int CMD_W = 32;
   localparam int TYPE_HI = 31;
   localparam int TYPE_LO = 29;
   localparam int OPC_HI = 28;
   localparam int OPC_LO = 23;
   localparam int RSV_HI = 22;
   localparam int ARB_CHK_RSV_LO = 0;
   localparam int ARB_TGL_RSV_LO = 1;
   localparam int ARB_EN_BIT = 0;
   localparam logic [2:0] MI_CMD_TYPE = 3'h0;
   localparam logic [5:0] OPC_ARB_CHECK = 6'h05;
   localparam logic [5:0] OPC_ARB_TOGGLE = 6'h08;
   localparam logic ARB_RESET_ENABLED = 1'h1;
   localparam int HEAD_W = 21;
   localparam int WRAP_W = 11;

   // Command word with the fetch context that decides privilege
   typedef struct packed {
      logic [CMD_W-1:0] word;
      logic from_batch;
      logic batch_secure;
   } acd_cmd_t;

   // Updated head pointer as software loaded it
   typedef struct packed {
      logic valid;
      logic [WRAP_W-1:0] wrap;
      logic [HEAD_W-1:0] head;
   } acd_uhp_t;

   typedef enum logic [1:0] {
      ACD_IDLE,
      ACD_RUN,
      ACD_STALL
   } acd_state_t;
endpackage : acd_pkg

// >>> hdl/acd_decode.sv
// Combinational decoder of one memory-interface command word.
// Assumes the word is stable while cmd_valid is high.
`timescale 1ns/10ps
`default_nettype none
module acd_decode (
   input wire acd_pkg::acd_cmd_t cmd,
   output logic is_check,
   output logic is_toggle,
   output logic toggle_value
);
   wire [2:0] cmd_type = cmd.word[acd_pkg::TYPE_HI:acd_pkg::TYPE_LO];
   wire [5:0] opc = cmd.word[acd_pkg::OPC_HI:acd_pkg::OPC_LO];
   wire mi_type = (cmd_type == acd_pkg::MI_CMD_TYPE);
   // Nonzero must-be-zero bits leave the word unrecognised
   wire chk_rsv_zero = ~|cmd.word[acd_pkg::RSV_HI:acd_pkg::ARB_CHK_RSV_LO];
   wire tgl_rsv_zero = ~|cmd.word[acd_pkg::RSV_HI:acd_pkg::ARB_TGL_RSV_LO];
   assign is_check = mi_type && (opc == acd_pkg::OPC_ARB_CHECK) && chk_rsv_zero; // [R05]
   assign is_toggle = mi_type && (opc == acd_pkg::OPC_ARB_TOGGLE) && tgl_rsv_zero; // [R16]
   assign toggle_value = cmd.word[acd_pkg::ARB_EN_BIT]; // [R07]
endmodule : acd_decode
`default_nettype wire

// >>> hdl/acd_head_load.sv
// Head pointer and wrap count holder of the ring.
// Assumes the fetch logic advances the head and reports wrap-arounds.
`timescale 1ns/10ps
`default_nettype none
module acd_head_load #(
   parameter int HEAD_W = acd_pkg::HEAD_W,
   parameter int WRAP_W = acd_pkg::WRAP_W
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic preempt,
   input wire logic [HEAD_W-1:0] new_head,
   input wire logic [WRAP_W-1:0] new_wrap,
   input wire logic advance,
   input wire logic [HEAD_W-1:0] adv_head,
   input wire logic wrapped,
   output logic [HEAD_W-1:0] head_q,
   output logic [WRAP_W-1:0] wrap_q
);
   logic [HEAD_W-1:0] head_d;
   logic [WRAP_W-1:0] wrap_d;
   // Pre-emption overrides normal advance; wrap is loaded, not counted
   assign head_d = preempt ? new_head : (advance ? adv_head : head_q); // [R01]
   assign wrap_d = preempt ? new_wrap : ((advance && wrapped) ? wrap_q + 1'b1 : wrap_q); // [R04]
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         head_q <= '0;
         wrap_q <= '0;
      end else begin
         head_q <= head_d;
         wrap_q <= wrap_d;
      end
   end
endmodule : acd_head_load
`default_nettype wire

// >>> hdl/acd_arb_ctrl.sv
// How it works
// [R01] An arbitration check consults the updated head pointer and pre-empts the ring with it.
// [R02] The check pre-empts only when the updated head pointer valid bit is set.
// [R03] Software places the check only in a ring buffer, never in a batch buffer.
// [R04] On pre-emption the wrap count is loaded from the updated head pointer.
// [R05] The check is type zero, opcode 05h, with all low bits zero.
// [R06] When the head equals the updated head pointer, its valid bit is cleared.
// [R07] Bit 0 of the toggle command disables (0) or enables (1) pre-emption switching.
// [R08] A disable holds until a later toggle command enables again.
// [R09] While disabled, no switch on event wait, command exhaustion or probe fault.
// [R10] Such an event while disabled leaves the engine stalled.
// [R11] While disabled, a new run list does not interrupt the sequence.
// [R12] Software brackets protected sequences with an off-then-on pair.
// [R13] Software disables arbitration sparingly.
// [R14] A toggle fetched from a non-secure batch buffer is a no-op.
// [R15] The toggle acts only when per-process address space with queuing is configured.
// [R16] The toggle is type zero, opcode 08h, with bits 22:1 zero.
// Assumes commands are presented one per cycle with cmd_valid, and that the
// context-switch logic outside acts on ctx_switch_q.
`timescale 1ns/10ps
`default_nettype none
module acd_arb_ctrl #(
   parameter int HEAD_W = acd_pkg::HEAD_W,
   parameter int WRAP_W = acd_pkg::WRAP_W
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic cmd_valid,
   input wire acd_pkg::acd_cmd_t cmd,
   input wire logic ppgtt_queue_en,
   input wire logic uhp_load,
   input wire acd_pkg::acd_uhp_t uhp_in,
   input wire logic head_advance,
   input wire logic [HEAD_W-1:0] head_next,
   input wire logic head_wrapped,
   input wire logic event_wait,
   input wire logic cmds_exhausted,
   input wire logic probe_fault,
   input wire logic new_run_list,
   output logic arb_enable_q,
   output logic uhp_valid_q,
   output logic preempt_q,
   output logic ctx_switch_q,
   output logic stalled_q,
   output logic [HEAD_W-1:0] head_q,
   output logic [WRAP_W-1:0] wrap_q
);
   logic is_check;
   logic is_toggle;
   logic toggle_value;
   logic [HEAD_W-1:0] uhp_head_q;
   logic [WRAP_W-1:0] uhp_wrap_q;
   logic arb_enable_d;
   logic uhp_valid_d;
   acd_pkg::acd_state_t state_q;
   acd_pkg::acd_state_t state_d;

   acd_decode u_dec (
      .cmd(cmd),
      .is_check(is_check),
      .is_toggle(is_toggle),
      .toggle_value(toggle_value)
   );

   // Check inside a batch buffer is ignored; software must not put it there
   wire check_go = cmd_valid && is_check && !cmd.from_batch; // [R03]
   wire preempt = check_go && uhp_valid_q; // [R02]
   // Privilege and configuration gate the toggle into a no-op
   wire toggle_ok = !cmd.from_batch || cmd.batch_secure; // [R14]
   wire toggle_go = cmd_valid && is_toggle && toggle_ok && ppgtt_queue_en; // [R15]
   wire switch_cause = event_wait || cmds_exhausted || probe_fault || new_run_list;
   wire hang_cause = event_wait || cmds_exhausted || probe_fault;
   wire head_match = (head_q == uhp_head_q);

   acd_head_load #(
      .HEAD_W(HEAD_W),
      .WRAP_W(WRAP_W)
   ) u_head (
      .clk(clk),
      .sys_rst(sys_rst),
      .preempt(preempt), // [R01]
      .new_head(uhp_head_q),
      .new_wrap(uhp_wrap_q),
      .advance(head_advance),
      .adv_head(head_next),
      .wrapped(head_wrapped),
      .head_q(head_q),
      .wrap_q(wrap_q)
   );

   assign arb_enable_d = toggle_go ? toggle_value : arb_enable_q; // [R07] [R08]
   // A fresh software load wins over the hardware clear in the same cycle
   assign uhp_valid_d = uhp_load ? uhp_in.valid
                      : ((head_match || preempt) ? 1'b0 : uhp_valid_q); // [R06]

   always_comb begin
      state_d = state_q;
      case (state_q)
         acd_pkg::ACD_IDLE: begin
            state_d = acd_pkg::ACD_RUN;
         end
         acd_pkg::ACD_RUN: begin
            if (!arb_enable_q && hang_cause) begin
               state_d = acd_pkg::ACD_STALL; // [R10]
            end
         end
         acd_pkg::ACD_STALL: begin
            // Only reset recovers; a disabled engine has no way out
            state_d = acd_pkg::ACD_STALL; // [R10]
         end
         default: begin
            state_d = acd_pkg::ACD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         arb_enable_q <= acd_pkg::ARB_RESET_ENABLED;
         uhp_valid_q <= 1'b0;
         uhp_head_q <= '0;
         uhp_wrap_q <= '0;
         state_q <= acd_pkg::ACD_IDLE;
      end else begin
         arb_enable_q <= arb_enable_d;
         uhp_valid_q <= uhp_valid_d;
         state_q <= state_d;
         if (uhp_load) begin
            uhp_head_q <= uhp_in.head;
            uhp_wrap_q <= uhp_in.wrap;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         preempt_q <= 1'b0;
         ctx_switch_q <= 1'b0;
         stalled_q <= 1'b0;
      end else begin
         preempt_q <= preempt;
         // Switches are suppressed entirely while arbitration is off
         ctx_switch_q <= arb_enable_q && switch_cause; // [R09] [R11]
         stalled_q <= (state_d == acd_pkg::ACD_STALL);
      end
   end

   // Raw type and opcode view, kept apart from the decoder so its checks are independent
   wire [acd_pkg::TYPE_HI-acd_pkg::OPC_LO:0] cmd_code =
      cmd.word[acd_pkg::TYPE_HI:acd_pkg::OPC_LO];
   wire code_check = (cmd_code == {acd_pkg::MI_CMD_TYPE, acd_pkg::OPC_ARB_CHECK});
   wire code_toggle = (cmd_code == {acd_pkg::MI_CMD_TYPE, acd_pkg::OPC_ARB_TOGGLE});

   chk_preempt_needs_valid: // [R02]
      assert property (@(posedge clk) disable iff (sys_rst)
         preempt_q |-> $past(uhp_valid_q))
      else $error("pre-emption without valid updated head pointer");

   chk_preempt_load_head: // [R01]
      assert property (@(posedge clk) disable iff (sys_rst)
         preempt_q |-> head_q == $past(uhp_head_q))
      else $error("head not loaded on pre-emption");

   chk_preempt_load_wrap: // [R04]
      assert property (@(posedge clk) disable iff (sys_rst)
         preempt_q |-> wrap_q == $past(uhp_wrap_q))
      else $error("wrap count not loaded on pre-emption");

   chk_valid_clear_match: // [R06]
      assert property (@(posedge clk) disable iff (sys_rst)
         (head_match && !uhp_load) |=> !uhp_valid_q)
      else $error("valid bit kept after head match");

   chk_toggle_sets_enable: // [R07]
      assert property (@(posedge clk) disable iff (sys_rst)
         toggle_go |=> arb_enable_q == $past(toggle_value))
      else $error("toggle bit not applied");

   chk_disable_holds: // [R08]
      assert property (@(posedge clk) disable iff (sys_rst)
         (!arb_enable_q && !toggle_go) |=> !arb_enable_q)
      else $error("arbitration re-enabled without toggle command");

   chk_no_switch_off: // [R09]
      assert property (@(posedge clk) disable iff (sys_rst)
         (!arb_enable_q && switch_cause) |=> !ctx_switch_q)
      else $error("context switch while arbitration off");

   chk_hang_stalls: // [R10]
      assert property (@(posedge clk) disable iff (sys_rst)
         (state_q == acd_pkg::ACD_RUN && !arb_enable_q && hang_cause) |=> stalled_q)
      else $error("engine not stalled on event while disabled");

   chk_runlist_blocked: // [R11]
      assert property (@(posedge clk) disable iff (sys_rst)
         (!arb_enable_q && new_run_list) |=> !ctx_switch_q)
      else $error("run list interrupted while disabled");

   chk_nonsecure_noop: // [R14]
      assert property (@(posedge clk) disable iff (sys_rst)
         (cmd_valid && is_toggle && cmd.from_batch && !cmd.batch_secure)
            |=> arb_enable_q == $past(arb_enable_q))
      else $error("non-secure toggle took effect");

   chk_unconfigured_noop: // [R15]
      assert property (@(posedge clk) disable iff (sys_rst)
         (cmd_valid && is_toggle && !ppgtt_queue_en) |=> $stable(arb_enable_q))
      else $error("toggle acted without queuing configuration");

   chk_check_decode: // [R05]
      assert property (@(posedge clk) disable iff (sys_rst)
         is_check ==
            (code_check && ~|cmd.word[acd_pkg::RSV_HI:acd_pkg::ARB_CHK_RSV_LO]))
      else $error("check decoded from wrong opcode");

   chk_toggle_decode: // [R16]
      assert property (@(posedge clk) disable iff (sys_rst)
         is_toggle ==
            (code_toggle && ~|cmd.word[acd_pkg::RSV_HI:acd_pkg::ARB_TGL_RSV_LO]))
      else $error("toggle decoded from wrong opcode");

   chk_batch_check_ignored: // [R03]
      assert property (@(posedge clk) disable iff (sys_rst)
         (cmd_valid && is_check && cmd.from_batch) |=> !preempt_q)
      else $error("check from batch buffer pre-empted");

   chk_invalid_no_preempt: // [R02]
      assert property (@(posedge clk) disable iff (sys_rst)
         (cmd_valid && !uhp_valid_q) |=> !preempt_q)
      else $error("pre-emption while updated head pointer invalid");

   chk_check_preempts: // [R01]
      assert property (@(posedge clk) disable iff (sys_rst)
         (cmd_valid && is_check && !cmd.from_batch && uhp_valid_q) |=> preempt_q)
      else $error("valid check did not pre-empt");

   chk_preempt_clears_valid: // [R06]
      assert property (@(posedge clk) disable iff (sys_rst)
         (preempt && !uhp_load) |=> !uhp_valid_q)
      else $error("valid bit kept after pre-emption");

   chk_load_sets_valid: // [R02]
      assert property (@(posedge clk) disable iff (sys_rst)
         uhp_load |=> uhp_valid_q == $past(uhp_in.valid))
      else $error("software load of valid bit lost");

   chk_valid_holds: // [R06]
      assert property (@(posedge clk) disable iff (sys_rst)
         (uhp_valid_q && !uhp_load && !head_match && !preempt) |=> uhp_valid_q)
      else $error("valid bit dropped without cause");

   chk_wrap_counts: // [R04]
      assert property (@(posedge clk) disable iff (sys_rst)
         (!preempt && head_advance && head_wrapped) |=> wrap_q == $past(wrap_q) + 1'b1)
      else $error("wrap count not advanced outside pre-emption");

   chk_wrap_hold: // [R04]
      assert property (@(posedge clk) disable iff (sys_rst)
         (!preempt && !(head_advance && head_wrapped)) |=> $stable(wrap_q))
      else $error("wrap count moved without wrap or pre-emption");

   chk_head_advance: // [R01]
      assert property (@(posedge clk) disable iff (sys_rst)
         (!preempt && head_advance) |=> head_q == $past(head_next))
      else $error("head not advanced");

   chk_enable_holds: // [R07]
      assert property (@(posedge clk) disable iff (sys_rst)
         (arb_enable_q && !toggle_go) |=> arb_enable_q)
      else $error("arbitration disabled without toggle command");

   chk_bad_rsv_toggle: // [R16]
      assert property (@(posedge clk) disable iff (sys_rst)
         (cmd_valid && code_toggle && |cmd.word[acd_pkg::RSV_HI:acd_pkg::ARB_TGL_RSV_LO])
            |=> $stable(arb_enable_q))
      else $error("toggle with reserved bits set took effect");

   chk_bad_rsv_check: // [R05]
      assert property (@(posedge clk) disable iff (sys_rst)
         (cmd_valid && code_check && |cmd.word[acd_pkg::RSV_HI:acd_pkg::ARB_CHK_RSV_LO])
            |=> !preempt_q)
      else $error("check with reserved bits set pre-empted");

   chk_secure_toggle_applies: // [R14]
      assert property (@(posedge clk) disable iff (sys_rst)
         (cmd_valid && is_toggle && cmd.from_batch && cmd.batch_secure && ppgtt_queue_en)
            |=> arb_enable_q == $past(toggle_value))
      else $error("secure batch toggle not applied");

   chk_switch_enabled: // [R09]
      assert property (@(posedge clk) disable iff (sys_rst)
         (arb_enable_q && switch_cause) |=> ctx_switch_q)
      else $error("no context switch while arbitration on");

   chk_runlist_enabled: // [R11]
      assert property (@(posedge clk) disable iff (sys_rst)
         (arb_enable_q && new_run_list) |=> ctx_switch_q)
      else $error("run list ignored while arbitration on");

   chk_stall_sticky: // [R10]
      assert property (@(posedge clk) disable iff (sys_rst)
         stalled_q |=> stalled_q)
      else $error("stall released without reset");

   chk_no_stall_enabled: // [R10]
      assert property (@(posedge clk) disable iff (sys_rst)
         (!stalled_q && arb_enable_q) |=> !stalled_q)
      else $error("stall while arbitration on");
endmodule : acd_arb_ctrl
`default_nettype wire

// >>> testbench/acd_sw_model.sv
// Driver-software model: hands single-dword commands to the decoder.
// Assumes the bench calls send; inputs change on falling edges only.
`timescale 1ns/10ps
`default_nettype none
module acd_sw_model (
   input wire logic clk,
   output var logic cmd_valid,
   output var acd_pkg::acd_cmd_t cmd
);
   initial begin
      cmd_valid = 1'h0;
      cmd = '0;
   end
   // Word is inverted once released so stale data never reads as a command
   task automatic send(input logic [31:0] word, input logic batch, input logic secure);
      @(negedge clk);
      cmd_valid = 1'h1;
      cmd = '{word: word, from_batch: batch, batch_secure: secure};
      @(negedge clk);
      cmd_valid = 1'h0;
      cmd = ~cmd;
   endtask : send
endmodule : acd_sw_model
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench of the arbitration command decoder.
// Assumes outputs settle one edge after a command is taken.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam logic [31:0] CHK = 32'h02800000;
   localparam logic [31:0] OFF = 32'h04000000;
   localparam logic [31:0] ON = 32'h04000001;
   logic clk, sys_rst, ppgtt_queue_en, uhp_load, head_advance, head_wrapped, cmd_valid;
   logic [2:0] cause;
   logic new_run_list;
   acd_pkg::acd_uhp_t uhp_in;
   acd_pkg::acd_cmd_t cmd;
   logic [20:0] head_next, head_q;
   logic [10:0] wrap_q;
   logic arb_enable_q, uhp_valid_q, preempt_q, ctx_switch_q, stalled_q;
   int n_mismatch = 0;
   int check_count = 0;
   int cyc = 0;
   acd_sw_model drv (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd));
   acd_arb_ctrl uut (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
      .ppgtt_queue_en(ppgtt_queue_en), .uhp_load(uhp_load), .uhp_in(uhp_in),
      .head_advance(head_advance), .head_next(head_next), .head_wrapped(head_wrapped),
      .event_wait(cause[0]), .cmds_exhausted(cause[1]), .probe_fault(cause[2]),
      .new_run_list(new_run_list), .arb_enable_q(arb_enable_q), .uhp_valid_q(uhp_valid_q),
      .preempt_q(preempt_q), .ctx_switch_q(ctx_switch_q), .stalled_q(stalled_q),
      .head_q(head_q), .wrap_q(wrap_q));
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   task automatic final_report;
      $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask : step
   task automatic do_reset;
      sys_rst = 1'h1;
      step(4);
      sys_rst = 1'h0;
      step(1);
   endtask : do_reset
   task automatic ld_uhp(input logic [10:0] w, input logic [20:0] h);
      @(negedge clk);
      uhp_load = 1'h1;
      uhp_in = '{valid: 1'h1, wrap: w, head: h};
      @(negedge clk);
      uhp_load = 1'h0;
      uhp_in = ~uhp_in;
   endtask : ld_uhp
   task automatic t_check;
      ld_uhp(11'h5a5, 21'h1abcd);
      drv.send(CHK | 32'h1, 1'h0, 1'h0);
      chk(preempt_q, 0);
      drv.send(CHK, 1'h1, 1'h0);
      chk(preempt_q, 0);
      drv.send(CHK, 1'h0, 1'h0);
      chk(preempt_q, 1);
      chk(head_q, 32'h1abcd);
      chk(wrap_q, 32'h5a5);
      step(1);
      chk(preempt_q, 0);
      chk(uhp_valid_q, 0);
      drv.send(CHK, 1'h0, 1'h0);
      chk(preempt_q, 0);
   endtask : t_check
   task automatic t_match;
      ld_uhp(11'h003, 21'h00040);
      step(2);
      chk(uhp_valid_q, 1);
      head_advance = 1'h1;
      head_next = 21'h00040;
      head_wrapped = 1'h1;
      step(1);
      head_advance = 1'h0;
      head_wrapped = 1'h0;
      head_next = ~head_next;
      chk(head_q, 32'h40);
      chk(wrap_q, 32'h5a6);
      step(2);
      chk(uhp_valid_q, 0);
   endtask : t_match
   task automatic t_toggle;
      drv.send(OFF, 1'h1, 1'h0);
      chk(arb_enable_q, 1);
      ppgtt_queue_en = 1'h0;
      drv.send(OFF, 1'h0, 1'h0);
      chk(arb_enable_q, 1);
      ppgtt_queue_en = 1'h1;
      drv.send(OFF | 32'h20, 1'h0, 1'h0);
      chk(arb_enable_q, 1);
      drv.send(OFF, 1'h1, 1'h1);
      chk(arb_enable_q, 0);
      drv.send(CHK, 1'h0, 1'h0);
      step(4);
      chk(arb_enable_q, 0);
      drv.send(ON, 1'h0, 1'h0);
      chk(arb_enable_q, 1);
   endtask : t_toggle
   task automatic t_switch;
      new_run_list = 1'h1;
      step(2);
      chk(ctx_switch_q, 1);
      drv.send(OFF, 1'h0, 1'h0);
      step(2);
      chk(ctx_switch_q, 0);
      new_run_list = 1'h0;
      // Stall is sticky, so each cause needs its own reset to be seen alone
      for (int i = 0; i < 3; i++) begin
         do_reset();
         drv.send(OFF, 1'h0, 1'h0);
         cause = 3'h1 << i;
         step(3);
         chk(ctx_switch_q, 0);
         chk(stalled_q, 1);
         cause = 3'h0;
      end
      drv.send(ON, 1'h0, 1'h0);
      chk(stalled_q, 1);
   endtask : t_switch
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         final_report();
      end
   end
   initial begin
      sys_rst = 1'h1;
      ppgtt_queue_en = 1'h1;
      uhp_load = 1'h0;
      uhp_in = '0;
      head_advance = 1'h0;
      head_wrapped = 1'h0;
      head_next = '0;
      cause = 3'h0;
      new_run_list = 1'h0;
      step(4);
      sys_rst = 1'h0;
      step(1);
      chk(arb_enable_q, 1);
      chk(stalled_q, 0);
      t_check();
      t_match();
      t_toggle();
      t_switch();
      final_report();
   end
endmodule : tb_top
`default_nettype wire
